// File: rtl/tx_buffer_descriptor_walk.sv
// transmit descriptor walker: follows the descriptor chain in host memory
// assumes memory and transmit path run on sys_clk; mem_ack is a one-cycle pulse
// Behaviour
// - first word is link to next descriptor
// - null link marks final buffer of queue
// - link field is never written back
// - link fetched late follows appended descriptor
// - null link already fetched halts until restart
// - end-of-queue marked on returned final descriptor
// - buffer address taken byte-aligned, never modified
// - offset skips leading bytes of buffer
// - offset applied on first fragment only
// - length counts valid bytes, offset excluded
// - single fragment length equals packet length
// - third word holds offset high, length low
// - fourth word holds flags high, packet length low
// - packet length equals sum of fragment lengths
// - ownership cleared on first descriptor when done
// - end-of-queue set on last descriptor with null
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module tx_buffer_descriptor_walk (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  output logic                        irq,
  output logic                        mem_req,
  output txd_walk_pkg::mem_cmd_s      mem_cmd,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata,
  output logic                        seg_valid,
  output txd_walk_pkg::segment_s      seg,
  input  wire logic                   seg_ready
);

  txd_walk_pkg::walk_state_e state_reg, state_next;
  logic [1:0]                      word_idx_reg, word_idx_next;
  logic [31:0]                     desc_addr_reg, desc_addr_next;
  logic [31:0]                     link_reg, link_next;
  logic [31:0]                     buf_reg, buf_next;
  logic [31:0]                     offlen_reg, offlen_next;
  logic [31:0]                     flags_reg, flags_next;
  logic [31:0]                     sop_addr_reg, sop_addr_next;
  logic [31:0]                     sop_word_reg, sop_word_next;
  logic [15:0]                     sum_reg, sum_next;
  logic [31:0]                     head_reg, head_next;
  logic [txd_walk_pkg::irq_width-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [txd_walk_pkg::irq_width-1:0] events;
  logic                            halted_reg, halted_next;
  logic [31:0]                     rdata_reg, rdata_next;
  logic                            seg_valid_reg, seg_valid_next;
  txd_walk_pkg::segment_s          seg_reg, seg_next;
  txd_walk_pkg::mem_cmd_s          cmd_reg, cmd_next;
  logic                            start;
  logic [15:0]                     total_len;

  assign start     = reg_wr && (reg_addr == txd_walk_pkg::ctrl_offset)
                     && reg_wdata[txd_walk_pkg::ctrl_start_bit];
  assign mem_req   = (state_reg == txd_walk_pkg::st_fetch)
                     || (state_reg == txd_walk_pkg::st_wb_eoq)
                     || (state_reg == txd_walk_pkg::st_wb_own);
  assign mem_cmd   = cmd_reg;
  assign seg_valid = seg_valid_reg;
  assign seg       = seg_reg;
  assign reg_rdata = rdata_reg;
  assign irq       = |(stat_reg & mask_reg);
  assign total_len = sum_reg + offlen_reg[15:0];

  // walk sequencer
  always_comb begin
    state_next     = state_reg;
    word_idx_next  = word_idx_reg;
    desc_addr_next = desc_addr_reg;
    link_next      = link_reg;
    buf_next       = buf_reg;
    offlen_next    = offlen_reg;
    flags_next     = flags_reg;
    sop_addr_next  = sop_addr_reg;
    sop_word_next  = sop_word_reg;
    sum_next       = sum_reg;
    halted_next    = halted_reg;
    seg_valid_next = seg_valid_reg;
    seg_next       = seg_reg;
    cmd_next       = cmd_reg;
    events         = '0;
    case (state_reg)
      txd_walk_pkg::st_idle: begin
        // a start with an empty head does nothing; avoids fetching address zero
        if (start && (head_reg != 32'h0000_0000)) begin
          state_next     = txd_walk_pkg::st_fetch;
          desc_addr_next = head_reg;
          word_idx_next  = txd_walk_pkg::word_link;
          cmd_next       = '{addr: head_reg, wdata: 32'h0000_0000, we: 1'b0};
          halted_next    = 1'b0;
        end
      end
      txd_walk_pkg::st_fetch: begin
        if (mem_ack) begin
          case (word_idx_reg)
            2'h0:    link_next   = mem_rdata;
            2'h1:    buf_next    = mem_rdata;
            2'h2:    offlen_next = mem_rdata;
            default: flags_next  = mem_rdata;
          endcase
          cmd_next.addr = cmd_reg.addr + txd_walk_pkg::word_step;
          word_idx_next = word_idx_reg + 2'h1;
          if (word_idx_reg == txd_walk_pkg::word_flags) begin
            state_next     = txd_walk_pkg::st_issue;
            seg_valid_next = 1'b1;
            seg_next.len   = offlen_reg[15:0];
            seg_next.first = mem_rdata[txd_walk_pkg::first_flag_bit];
            seg_next.last  = mem_rdata[txd_walk_pkg::last_flag_bit];
            if (mem_rdata[txd_walk_pkg::first_flag_bit]) begin
              // offset honoured only on the first fragment
              seg_next.addr = buf_reg + {16'h0000,
                offlen_reg[txd_walk_pkg::half_msb:txd_walk_pkg::half_lsb]};
              sop_addr_next = desc_addr_reg;
              sop_word_next = mem_rdata;
              sum_next      = 16'h0000;
            end else begin
              seg_next.addr = buf_reg;
            end
          end
        end
      end
      txd_walk_pkg::st_issue: begin
        if (seg_ready) begin
          seg_valid_next = 1'b0;
          sum_next       = sum_reg + offlen_reg[15:0];
          cmd_next.we    = 1'b1;
          cmd_next.addr  = desc_addr_reg + txd_walk_pkg::flags_word_offset;
          if (seg_reg.last) begin
            // packet length is carried by the first descriptor only
            if (total_len != sop_word_reg[15:0]) begin
              events[txd_walk_pkg::irq_len_err_bit] = 1'b1;
            end
            if (link_reg == 32'h0000_0000) begin
              state_next     = txd_walk_pkg::st_wb_eoq;
              cmd_next.wdata = flags_reg | (32'h1 << txd_walk_pkg::queue_end_bit);
            end else begin
              state_next     = txd_walk_pkg::st_wb_own;
              cmd_next.addr  = sop_addr_reg + txd_walk_pkg::flags_word_offset;
              cmd_next.wdata = sop_word_reg & ~(32'h1 << txd_walk_pkg::owned_flag_bit);
            end
          end else if (link_reg == 32'h0000_0000) begin
            // chain broken mid-packet: stop without touching memory
            state_next  = txd_walk_pkg::st_idle;
            halted_next = 1'b1;
            events[txd_walk_pkg::irq_halted_bit] = 1'b1;
            cmd_next.we = 1'b0;
          end else begin
            state_next     = txd_walk_pkg::st_fetch;
            desc_addr_next = link_reg;
            word_idx_next  = txd_walk_pkg::word_link;
            cmd_next       = '{addr: link_reg, wdata: 32'h0000_0000, we: 1'b0};
          end
        end
      end
      txd_walk_pkg::st_wb_eoq: begin
        if (mem_ack) begin
          state_next     = txd_walk_pkg::st_wb_own;
          cmd_next.addr  = sop_addr_reg + txd_walk_pkg::flags_word_offset;
          // single-fragment packet: keep the queue end mark in the same word
          cmd_next.wdata = ((sop_addr_reg == desc_addr_reg) ? cmd_reg.wdata : sop_word_reg)
                           & ~(32'h1 << txd_walk_pkg::owned_flag_bit);
        end
      end
      txd_walk_pkg::st_wb_own: begin
        if (mem_ack) begin
          events[txd_walk_pkg::irq_pkt_done_bit] = 1'b1;
          if (link_reg == 32'h0000_0000) begin
            // the null link was already read, so a late append waits for a restart
            state_next  = txd_walk_pkg::st_idle;
            halted_next = 1'b1;
            events[txd_walk_pkg::irq_halted_bit] = 1'b1;
            cmd_next.we = 1'b0;
          end else begin
            // link is re-read per descriptor, so an append made in time is followed
            state_next     = txd_walk_pkg::st_fetch;
            desc_addr_next = link_reg;
            word_idx_next  = txd_walk_pkg::word_link;
            cmd_next       = '{addr: link_reg, wdata: 32'h0000_0000, we: 1'b0};
          end
        end
      end
      default: begin
        state_next = txd_walk_pkg::st_idle;
      end
    endcase
  end

  // register port, sticky status with set winning over clear
  always_comb begin
    head_next  = head_reg;
    mask_next  = mask_reg;
    stat_next  = stat_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        txd_walk_pkg::head_offset:     head_next = reg_wdata;
        txd_walk_pkg::irq_mask_offset: mask_next = reg_wdata[txd_walk_pkg::irq_width-1:0];
        txd_walk_pkg::irq_stat_offset:
          stat_next = stat_reg & ~reg_wdata[txd_walk_pkg::irq_width-1:0];
        default: ;
      endcase
    end
    stat_next = stat_next | events;
    if (reg_rd) begin
      case (reg_addr)
        txd_walk_pkg::head_offset:     rdata_next = head_reg;
        txd_walk_pkg::state_offset:
          rdata_next = {27'h0, halted_reg, state_reg, (state_reg != txd_walk_pkg::st_idle)};
        txd_walk_pkg::irq_stat_offset: rdata_next = {29'h0, stat_reg};
        txd_walk_pkg::irq_mask_offset: rdata_next = {29'h0, mask_reg};
        txd_walk_pkg::cur_desc_offset: rdata_next = desc_addr_reg;
        default:                       rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg     <= txd_walk_pkg::st_idle;
      word_idx_reg  <= 2'h0;
      desc_addr_reg <= 32'h0000_0000;
      link_reg      <= 32'h0000_0000;
      buf_reg       <= 32'h0000_0000;
      offlen_reg    <= 32'h0000_0000;
      flags_reg     <= 32'h0000_0000;
      sop_addr_reg  <= 32'h0000_0000;
      sop_word_reg  <= 32'h0000_0000;
      sum_reg       <= 16'h0000;
      head_reg      <= 32'h0000_0000;
      stat_reg      <= '0;
      mask_reg      <= txd_walk_pkg::irq_mask_reset;
      halted_reg    <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      seg_valid_reg <= 1'b0;
      seg_reg       <= '0;
      cmd_reg       <= '0;
    end else begin
      state_reg     <= state_next;
      word_idx_reg  <= word_idx_next;
      desc_addr_reg <= desc_addr_next;
      link_reg      <= link_next;
      buf_reg       <= buf_next;
      offlen_reg    <= offlen_next;
      flags_reg     <= flags_next;
      sop_addr_reg  <= sop_addr_next;
      sop_word_reg  <= sop_word_next;
      sum_reg       <= sum_next;
      head_reg      <= head_next;
      stat_reg      <= stat_next;
      mask_reg      <= mask_next;
      halted_reg    <= halted_next;
      rdata_reg     <= rdata_next;
      seg_valid_reg <= seg_valid_next;
      seg_reg       <= seg_next;
      cmd_reg       <= cmd_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence link_word_taken;
    mem_ack && (state_reg == txd_walk_pkg::st_fetch) && (word_idx_reg == 2'h0);
  endsequence

  chk_write_flags_only: assert property (
    mem_req && mem_cmd.we |->
      (mem_cmd.addr == desc_addr_reg + txd_walk_pkg::flags_word_offset)
      || (mem_cmd.addr == sop_addr_reg + txd_walk_pkg::flags_word_offset))
    else $error("walker wrote a descriptor word other than the flags word");

  chk_fetch_word_order: assert property (
    link_word_taken |=> mem_req && !mem_cmd.we && (mem_cmd.addr == desc_addr_reg + 32'h4)
                        && (link_reg == $past(mem_rdata)))
    else $error("buffer address word not fetched right after link word");

  chk_hardware_owned_flag_cleared: assert property (
    (state_reg == txd_walk_pkg::st_wb_own) && mem_req |->
      !mem_cmd.wdata[txd_walk_pkg::owned_flag_bit] && (mem_cmd.addr == sop_addr_reg + 32'hC))
    else $error("ownership not cleared on first descriptor");

  chk_queue_end_mark: assert property (
    (state_reg == txd_walk_pkg::st_wb_eoq) |->
      mem_cmd.wdata[txd_walk_pkg::queue_end_bit] && (link_reg == 32'h0) && seg_reg.last)
    else $error("queue end written without a null link on last fragment");

  chk_null_link_halt: assert property (
    mem_ack && (state_reg == txd_walk_pkg::st_wb_own) && (link_reg == 32'h0)
      |=> (state_reg == txd_walk_pkg::st_idle) && halted_reg
          && stat_reg[txd_walk_pkg::irq_halted_bit])
    else $error("walker did not halt on a null link");

  chk_follow_link: assert property (
    mem_ack && (state_reg == txd_walk_pkg::st_wb_own) && (link_reg != 32'h0)
      |=> (state_reg == txd_walk_pkg::st_fetch) && (mem_cmd.addr == $past(link_reg)))
    else $error("appended descriptor not followed");

  chk_segment_start: assert property (
    seg_valid |-> seg.addr == buf_reg + (seg.first ? {16'h0, offlen_reg[31:16]} : 32'h0))
    else $error("segment start does not match offset rule");

  chk_segment_len: assert property (
    seg_valid && !seg_ready |=> seg_valid && $stable(seg) && (seg.len == offlen_reg[15:0]))
    else $error("segment changed or wrong length while stalled");

  chk_len_mismatch: assert property (
    seg_valid && seg_ready && seg.last && (total_len != sop_word_reg[15:0])
      |=> stat_reg[txd_walk_pkg::irq_len_err_bit])
    else $error("packet length mismatch not flagged");

endmodule : tx_buffer_descriptor_walk

// File: rtl/txd_walk_pkg.sv
// constants, field layout and carriers for the transmit descriptor walker
// assumes a 32-bit byte-addressed host memory with word-aligned descriptors
package txd_walk_pkg;

  // register map of the walker's own control port
  localparam logic [7:0] ctrl_offset      = 8'h00;
  localparam logic [7:0] head_offset      = 8'h04;
  localparam logic [7:0] state_offset     = 8'h08;
  localparam logic [7:0] irq_stat_offset  = 8'h0C;
  localparam logic [7:0] irq_mask_offset  = 8'h10;
  localparam logic [7:0] cur_desc_offset  = 8'h14;
  localparam int         ctrl_start_bit   = 0;

  // sticky event bits, same layout in status and mask
  localparam int          irq_width         = 3;
  localparam int          irq_pkt_done_bit  = 0;
  localparam int          irq_halted_bit    = 1;
  localparam int          irq_len_err_bit   = 2;
  localparam logic [2:0]  irq_mask_reset    = 3'h0;

  // descriptor word layout
  localparam logic [31:0] word_step         = 32'h0000_0004;
  localparam logic [31:0] flags_word_offset = 32'h0000_000C;
  localparam logic [1:0]  word_link         = 2'h0;
  localparam logic [1:0]  word_flags        = 2'h3;
  localparam int          first_flag_bit    = 31;
  localparam int          last_flag_bit     = 30;
  localparam int          owned_flag_bit    = 29;
  localparam int          queue_end_bit     = 28;
  localparam int          half_msb          = 31;
  localparam int          half_lsb          = 16;

  typedef enum logic [2:0] {
    st_idle   = 3'h0,
    st_fetch  = 3'h1,
    st_issue  = 3'h2,
    st_wb_eoq = 3'h3,
    st_wb_own = 3'h4
  } walk_state_e;

  // one buffer segment handed to the transmit path
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] len;
    logic        first;
    logic        last;
  } segment_s;

  // host memory request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        we;
  } mem_cmd_s;

endpackage : txd_walk_pkg

// File: test/host_memory_model.sv
// host memory holding descriptor chains, answers walker word accesses
// assumes mem_cmd holds until mem_ack; bench sets the wait and fills mem
`timescale 1ns/1ps

module host_memory_model (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   mem_req,
  input  wire txd_walk_pkg::mem_cmd_s mem_cmd,
  input  wire logic [3:0]             wait_cycles,
  output logic                        mem_ack,
  output logic      [31:0]            mem_rdata
);
  logic [31:0] mem [0:63];
  logic [31:0] rd_reg;
  logic [3:0]  wait_reg;

  // stale read data is inverted so it never passes as a match
  assign mem_rdata = mem_ack ? rd_reg : ~rd_reg;

  // plain always: the bench also writes mem as software would
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mem_ack  <= 1'b0;
      wait_reg <= 4'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack  <= 1'b0;
      wait_reg <= wait_cycles;
    end else if (wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end else begin
      mem_ack <= 1'b1;
      rd_reg  <= mem[mem_cmd.addr[7:2]];
      if (mem_cmd.we) begin
        mem[mem_cmd.addr[7:2]] <= mem_cmd.wdata;
      end
    end
  end
endmodule : host_memory_model

// File: test/tx_buffer_descriptor_walk_test.sv
// self-checking bench for the descriptor walker
// assumes descriptors live in the model's 256-byte memory
`timescale 1ns/1ps

module tx_buffer_descriptor_walk_test;
  logic                   sys_clk = 1'b0;
  logic                   reset   = 1'b1;
  logic [7:0]             reg_addr = 8'h00;
  logic [31:0]            reg_wdata = 32'h0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [31:0]            reg_rdata;
  logic                   irq;
  logic                   mem_req;
  txd_walk_pkg::mem_cmd_s mem_cmd;
  logic                   mem_ack;
  logic [31:0]            mem_rdata;
  logic                   seg_valid;
  txd_walk_pkg::segment_s seg;
  logic                   seg_ready = 1'b0;
  logic [3:0]             wait_cycles = 4'h0;
  logic                   slow = 1'b0;
  logic [31:0]            rs = 32'hAD75;
  logic [31:0]            sr = 32'hAD75;
  logic [31:0]            orig [0:63];
  logic [31:0]            fexp [0:63];
  logic [31:0]            d;
  logic [15:0]            l0;
  txd_walk_pkg::segment_s got [$];
  txd_walk_pkg::segment_s exp [$];
  int                     fail_count = 0;
  int                     num_checks = 0;

  tx_buffer_descriptor_walk i_tx_buffer_descriptor_walk (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .seg_valid(seg_valid), .seg(seg),
    .seg_ready(seg_ready));
  host_memory_model i_host_memory_model (.sys_clk(sys_clk), .reset(reset),
    .mem_req(mem_req), .mem_cmd(mem_cmd), .wait_cycles(wait_cycles),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction : xs

  // offset counts only on the first fragment
  function automatic txd_walk_pkg::segment_s exp_seg(input logic [31:0] b,
    input logic [15:0] off, input logic [15:0] len, input logic f, input logic l);
    exp_seg.addr  = f ? b + {16'h0000, off} : b;
    exp_seg.len   = len;
    exp_seg.first = f;
    exp_seg.last  = l;
  endfunction : exp_seg

  // transmit path stalls at random; memory is slow only when asked
  always @(posedge sys_clk) begin
    if (seg_valid === 1'b1 && seg_ready === 1'b1) begin
      got.push_back(seg);
    end
    sr = xs(sr);
    seg_ready   <= sr[0] | sr[1];
    wait_cycles <= slow ? sr[7:4] : 4'h0;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask : reg_read

  // software builds a descriptor before it joins the list
  task automatic desc(input logic [7:0] a, input logic [7:0] nxt, input logic [31:0] b,
    input logic [15:0] off, input logic [15:0] len, input logic f, input logic l,
    input logic [15:0] pl);
    orig[a[7:2]]     = {24'h000000, nxt};
    orig[a[7:2] + 1] = b;
    orig[a[7:2] + 2] = {off, len};
    orig[a[7:2] + 3] = {f, l, f, 1'b0, 12'h000, pl};
    for (int k = 0; k < 4; k++) begin
      fexp[a[7:2] + k] = orig[a[7:2] + k];
      i_host_memory_model.mem[a[7:2] + k] = orig[a[7:2] + k];
    end
    exp.push_back(exp_seg(b, off, len, f, l));
  endtask : desc

  // append: only a null link is ever replaced
  task automatic link(input logic [7:0] a, input logic [7:0] nxt);
    orig[a[7:2]] = {24'h000000, nxt};
    fexp[a[7:2]] = orig[a[7:2]];
    i_host_memory_model.mem[a[7:2]] = orig[a[7:2]];
  endtask : link

  task automatic go(input logic [7:0] h);
    reg_write(txd_walk_pkg::head_offset, {24'h000000, h});
    reg_write(txd_walk_pkg::ctrl_offset, 32'h0000_0001);
  endtask : go

  task automatic wait_done();
    logic [31:0] v;
    v = 32'h1;
    for (int n = 0; v[0] !== 1'b0; n++) begin
      if (n > 300) begin
        fail_count++;
        finish_test();
      end
      reg_read(txd_walk_pkg::state_offset, v);
    end
    check(got.size(), exp.size());
    foreach (exp[k]) begin
      if (k < got.size()) check(got[k], exp[k]);
    end
    for (int k = 4; k < 40; k++) begin
      check(i_host_memory_model.mem[k], fexp[k]);
    end
    got.delete();
    exp.delete();
  endtask : wait_done

  initial begin
    for (int k = 0; k < 64; k++) begin
      orig[k] = 32'h0;
      fexp[k] = 32'h0;
      i_host_memory_model.mem[k] = 32'h0;
    end
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    check(irq, 1'b0);
    reg_read(txd_walk_pkg::irq_mask_offset, d);
    check(d, 32'h0);
    reg_write(8'h3C, 32'hFFFF_FFFF);
    reg_read(8'h3C, d);
    check(d, 32'h0);
    // single fragment, then two fragments with a wrong packet length
    rs = xs(rs);
    l0 = {10'h000, rs[5:0]} + 16'h0010;
    desc(8'h10, 8'h20, rs, {12'h000, rs[9:6]}, l0, 1'b1, 1'b1, l0);
    desc(8'h20, 8'h30, ~rs, 16'h000F, l0 + 16'h0003, 1'b1, 1'b0, 16'h0001);
    desc(8'h30, 8'h00, rs ^ 32'h5A5A_0F0F, 16'h0007, 16'h0020, 1'b0, 1'b1, 16'h0000);
    fexp[7][txd_walk_pkg::owned_flag_bit]   = 1'b0;
    fexp[11][txd_walk_pkg::owned_flag_bit]  = 1'b0;
    fexp[15][txd_walk_pkg::queue_end_bit]   = 1'b1;
    go(8'h10);
    wait_done();
    reg_read(txd_walk_pkg::irq_stat_offset, d);
    check(d & 32'h5, 32'h5);
    check(irq, 1'b0);
    reg_write(txd_walk_pkg::irq_mask_offset, 32'h4);
    check(irq, 1'b1);
    reg_write(txd_walk_pkg::irq_stat_offset, 32'h4);
    check(irq, 1'b0);
    reg_write(txd_walk_pkg::irq_stat_offset, 32'h7);
    // append in time on a slow memory: walker must not stop
    slow = 1'b1;
    desc(8'h40, 8'h50, rs + 32'h3, 16'h0000, 16'h0001, 1'b1, 1'b1, 16'h0001);
    desc(8'h50, 8'h00, rs + 32'h9, 16'h0002, 16'h0040, 1'b1, 1'b1, 16'h0040);
    desc(8'h60, 8'h00, rs + 32'h1, 16'h0001, 16'h0005, 1'b1, 1'b1, 16'h0005);
    go(8'h40);
    link(8'h50, 8'h60);
    fexp[19][txd_walk_pkg::owned_flag_bit] = 1'b0;
    fexp[23][txd_walk_pkg::owned_flag_bit] = 1'b0;
    fexp[27][txd_walk_pkg::owned_flag_bit] = 1'b0;
    fexp[27][txd_walk_pkg::queue_end_bit]  = 1'b1;
    wait_done();
    reg_read(txd_walk_pkg::irq_stat_offset, d);
    check(d[2], 1'b0);
    // append too late: halted until restarted
    desc(8'h70, 8'h00, rs, 16'h0003, 16'h0010, 1'b1, 1'b1, 16'h0010);
    link(8'h60, 8'h70);
    repeat (40) @(posedge sys_clk);
    check(got.size(), 0);
    check(i_host_memory_model.mem[27][txd_walk_pkg::queue_end_bit], 1'b1);
    reg_read(txd_walk_pkg::state_offset, d);
    check(d, 32'h0000_0010);
    reg_read(txd_walk_pkg::cur_desc_offset, d);
    check(d, 32'h0000_0060);
    reg_read(txd_walk_pkg::head_offset, d);
    check(d, 32'h0000_0040);
    go(8'h70);
    fexp[31][txd_walk_pkg::owned_flag_bit] = 1'b0;
    fexp[31][txd_walk_pkg::queue_end_bit]  = 1'b1;
    wait_done();
    // chain broken inside a packet: segment goes out, nothing written back
    reg_write(txd_walk_pkg::irq_stat_offset, 32'h7);
    desc(8'h80, 8'h00, rs, 16'h0002, 16'h0008, 1'b1, 1'b0, 16'h0008);
    go(8'h80);
    wait_done();
    reg_read(txd_walk_pkg::irq_stat_offset, d);
    check(d, 32'h0000_0002);
    finish_test();
  end
endmodule : tx_buffer_descriptor_walk_test
